// *** ssp_consts.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADDR_W        8
`define SSP_OFF_CTRL      8'h00
`define SSP_OFF_DATA      8'h04
`define SSP_OFF_STAT      8'h08
`define SSP_OFF_RAW       8'h0C
`define SSP_OFF_MASK      8'h10
`define SSP_OFF_MIS       8'h14
`define SSP_OFF_ICLR      8'h18
`define SSP_OFF_DMA_SET   8'h1C
`define SSP_OFF_DMA_CLR   8'h20
`define SSP_OFF_DMA       8'h24
`define SSP_OFF_PUT       8'h28
`define SSP_CTRL_EN_BIT   0
`define SSP_CTRL_WID_LSB  4
`define SSP_CTRL_WID_MSB  7
`define SSP_CTRL_RESET    32'h0000_0070
`define SSP_WID_RESET     4'h7
`define SSP_INT_TXFF      0
`define SSP_INT_RXFF      1
`define SSP_INT_RXTO      2
`define SSP_INT_RXOR      3
`define SSP_DMA_RX        0
`define SSP_DMA_TX        1
`define SSP_STAT_BUSY     0
`define SSP_STAT_NOTFULL  1
`define SSP_STAT_EMPTY    2
`define SSP_WID_MIN       4'h3
`define SSP_FIFO_DEPTH    8
`define SSP_HALF_BIT_NS   40
`define SSP_CLK_NS        10
`define SSP_HALF_BIT_CYC  (`SSP_HALF_BIT_NS / `SSP_CLK_NS)
`endif

// *** ssp_ctrl.sv ***
// Serial port control: registers, transmit path, DMA and interrupts
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_ctrl
	import ssp_pkg::*;
#(
	parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH,
	parameter int HALF_BIT   = `SSP_HALF_BIT_CYC
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst,
	input  wire logic [`SSP_ADDR_W-1:0] i_addr,
	input  wire logic [31:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic [31:0]                 o_rdata,
	output logic                        o_irq,
	output logic                        o_rx_dma_req,
	output logic                        o_tx_dma_req,
	input  wire logic                   i_rx_fifo_service,
	input  wire logic                   i_rx_timeout,
	input  wire logic                   i_rx_overrun,
	output logic                        o_sclk,
	output logic                        o_sclk_oe,
	output logic                        o_mosi,
	output logic                        o_mosi_oe,
	output logic                        o_fss_n
);
	logic        port_en;
	logic [3:0]  wid_m1;
	logic [1:0]  dma_en;
	logic [3:0]  raw;
	logic [3:0]  mask;
	logic        put_ok;
	ssp_tx_state_e state;
	ssp_word_t   shreg;
	logic [3:0]  bit_cnt;
	logic [7:0]  half_cnt;
	logic        fifo_full;
	logic        fifo_empty;
	logic        fifo_rd;
	ssp_word_t   fifo_q;
	ssp_word_t   wr_trunc;
	logic [15:0] wid_mask;
	logic        wr_data;
	logic        wr_put;
	logic        rx_svc_s1;
	logic        rx_svc_s2;
	logic        rx_to_s1;
	logic        rx_to_s2;
	logic        rx_or_s1;
	logic        rx_or_s2;
	logic        busy;
	logic        half_tick;
	logic [3:0]  events;
	logic        wr_ctrl;
	logic        wr_mask;
	logic        wr_iclr;
	logic        wr_dma_set;
	logic        wr_dma_clr;
	logic        port_off;
	logic [3:0]  next_wid;
	logic [31:0] next_rdata;

	assign wr_data = i_wr && (i_addr == `SSP_OFF_DATA);
	assign wr_put  = i_wr && (i_addr == `SSP_OFF_PUT);
	assign wr_ctrl    = i_wr && (i_addr == `SSP_OFF_CTRL);
	assign wr_mask    = i_wr && (i_addr == `SSP_OFF_MASK);
	assign wr_iclr    = i_wr && (i_addr == `SSP_OFF_ICLR);
	assign wr_dma_set = i_wr && (i_addr == `SSP_OFF_DMA_SET);
	assign wr_dma_clr = i_wr && (i_addr == `SSP_OFF_DMA_CLR);

	// Abort in the same edge as the disabling write, so no stray clock
	// edge or frame strobe escapes after software turns the port off
	assign port_off = !port_en || (wr_ctrl && !i_wdata[`SSP_CTRL_EN_BIT]);

	// Keep only the configured width
	always_comb begin
		wid_mask = 16'h0000;
		for (int k = 0; k < 16; k++)
			wid_mask[k] = (4'(k) <= wid_m1);
	end
	assign wr_trunc = ssp_word_t'(i_wdata[15:0]) & wid_mask;

	// Disabled port flushes, so stale words never go out after re-enable
	ssp_tx_fifo #(
		.DEPTH (FIFO_DEPTH),
		.AW    ($clog2(FIFO_DEPTH))
	) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_flush   (!port_en),
		.i_wr      ((wr_data || wr_put) && port_en),
		.i_wr_data (wr_trunc),
		.i_rd      (fifo_rd),
		.o_rd_data (fifo_q),
		.o_full    (fifo_full),
		.o_empty   (fifo_empty)
	);

	// Control register; width below four is held at four
	always_comb begin
		next_wid = i_wdata[`SSP_CTRL_WID_MSB:`SSP_CTRL_WID_LSB];
		if (next_wid < `SSP_WID_MIN)
			next_wid = `SSP_WID_MIN;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			port_en <= 1'b0;
			wid_m1  <= `SSP_WID_RESET;
		end else if (wr_ctrl) begin
			port_en <= i_wdata[`SSP_CTRL_EN_BIT];
			wid_m1  <= next_wid;
		end
	end

	// DMA enables: set and clear only the masked directions
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			dma_en <= 2'h0;
		else if (wr_dma_set)
			dma_en <= dma_en | i_wdata[1:0];
		else if (wr_dma_clr)
			dma_en <= dma_en & ~i_wdata[1:0];
	end
	// Requests rely on a DMA controller already set up
	assign o_tx_dma_req = dma_en[`SSP_DMA_TX] && port_en && !fifo_full;
	assign o_rx_dma_req = dma_en[`SSP_DMA_RX] && port_en && rx_svc_s2;

	// Receive-side events come from another domain
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rx_svc_s1 <= 1'b0;
			rx_svc_s2 <= 1'b0;
			rx_to_s1  <= 1'b0;
			rx_to_s2  <= 1'b0;
			rx_or_s1  <= 1'b0;
			rx_or_s2  <= 1'b0;
		end else begin
			rx_svc_s1 <= i_rx_fifo_service;
			rx_svc_s2 <= rx_svc_s1;
			rx_to_s1  <= i_rx_timeout;
			rx_to_s2  <= rx_to_s1;
			rx_or_s1  <= i_rx_overrun;
			rx_or_s2  <= rx_or_s1;
		end
	end

	// Disabled port raises nothing
	assign events[`SSP_INT_TXFF] = port_en && !fifo_full;
	assign events[`SSP_INT_RXFF] = port_en && rx_svc_s2;
	assign events[`SSP_INT_RXTO] = port_en && rx_to_s2;
	assign events[`SSP_INT_RXOR] = port_en && rx_or_s2;

	// FIFO service sources are levels; timeout and overrun are sticky
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			raw <= 4'h0;
		end else begin
			raw[`SSP_INT_TXFF] <= events[`SSP_INT_TXFF];
			raw[`SSP_INT_RXFF] <= events[`SSP_INT_RXFF];
			// Set wins over a same-cycle clear
			for (int k = `SSP_INT_RXTO; k <= `SSP_INT_RXOR; k++) begin
				if (events[k])
					raw[k] <= 1'b1;
				else if (wr_iclr && i_wdata[k])
					raw[k] <= 1'b0;
			end
		end
	end

	// Enables set and cleared independently by plain write
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			mask <= 4'h0;
		else if (wr_mask)
			mask <= i_wdata[3:0];
	end

	// Level output; software clears the source or its enable to drop it
	assign o_irq = |(raw & mask);

	// Put-try result kept for the following read
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			put_ok <= 1'b0;
		else if (wr_put)
			put_ok <= port_en && !fifo_full;
	end

	// Transmit shifter, half-bit ticks from the system clock
	assign half_tick = (half_cnt == 8'(HALF_BIT - 1));
	assign fifo_rd = port_en && (state != SSP_SHIFT) && !fifo_empty &&
		(state == SSP_IDLE || half_tick);

	// Counter rests in idle so every frame starts a full half-bit late
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || port_off || state == SSP_IDLE || half_tick)
			half_cnt <= 8'h00;
		else
			half_cnt <= half_cnt + 8'h01;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || port_off) begin
			state   <= SSP_IDLE;
			shreg   <= '0;
			bit_cnt <= 4'h0;
			o_sclk  <= 1'b0;
		end else begin
			unique case (state)
				SSP_IDLE: begin
					if (!fifo_empty) begin
						shreg   <= fifo_q;
						bit_cnt <= wid_m1;
						state   <= SSP_SHIFT;
					end
				end
				SSP_SHIFT: begin
					if (half_tick) begin
						o_sclk <= !o_sclk;
						if (o_sclk) begin
							shreg <= {shreg[14:0], 1'b0};
							if (bit_cnt == 4'h0)
								state <= SSP_LAST;
							else
								bit_cnt <= bit_cnt - 4'h1;
						end
					end
				end
				SSP_LAST: begin
					if (half_tick) begin
						if (!fifo_empty) begin
							shreg   <= fifo_q;
							bit_cnt <= wid_m1;
							state   <= SSP_SHIFT;
						end else begin
							state <= SSP_IDLE;
						end
					end
				end
				default: state <= SSP_IDLE;
			endcase
		end
	end

	// Registered so the pin never glitches while width or shifter settle;
	// the extra cycle is well inside the half-bit setup time
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || port_off)
			o_mosi <= 1'b0;
		else
			o_mosi <= shreg[wid_m1];
	end

	assign o_mosi_oe = port_en;
	assign o_sclk_oe = port_en;
	// Strobe stays low across back-to-back words
	assign o_fss_n   = !(state != SSP_IDLE);
	assign busy      = !fifo_empty || state != SSP_IDLE;

	// Read data one cycle after the strobe; unmapped reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				`SSP_OFF_CTRL:
					next_rdata = {24'h0, wid_m1, 3'h0, port_en};
				`SSP_OFF_STAT:
					next_rdata = {29'h0, fifo_empty, !fifo_full, busy};
				`SSP_OFF_RAW:  next_rdata = {28'h0, raw};
				`SSP_OFF_MASK: next_rdata = {28'h0, mask};
				`SSP_OFF_MIS:  next_rdata = {28'h0, raw & mask};
				`SSP_OFF_DMA:  next_rdata = {30'h0, dma_en};
				`SSP_OFF_PUT:  next_rdata = {31'h0, put_ok};
				default:       next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_rdata <= 32'h0000_0000;
		else
			o_rdata <= next_rdata;
	end
endmodule
`default_nettype wire

// *** ssp_ctrl_asserts.sv ***
// Port-level checks for the serial port control block
`timescale 1ns/100ps
`default_nettype none
module ssp_ctrl_asserts #(
	parameter int FIFO_DEPTH = 8,
	parameter int HALF_BIT   = 4
) (
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic        i_rd,
	input wire logic        i_rx_fifo_service,
	input wire logic [31:0] o_rdata,
	input wire logic        o_irq,
	input wire logic        o_rx_dma_req,
	input wire logic        o_tx_dma_req,
	input wire logic        o_sclk,
	input wire logic        o_sclk_oe,
	input wire logic        o_mosi_oe,
	input wire logic        o_fss_n
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside answer");
	AST_OFF_FRAME: assert property (!o_sclk_oe |-> o_fss_n)
		else $error("frame active while disabled");
	AST_OFF_DMA: assert property (!o_sclk_oe |-> !o_tx_dma_req && !o_rx_dma_req)
		else $error("dma request while disabled");
	AST_OE_PAIR: assert property (o_mosi_oe == o_sclk_oe)
		else $error("data and clock enables differ");
	AST_HALF_BIT: assert property ($rose(o_sclk) |=> (o_sclk || !o_sclk_oe)[*3])
		else $error("serial clock high phase too short");
	AST_SCLK_FRAME: assert property (o_sclk |-> !o_fss_n)
		else $error("serial clock outside frame");
	AST_RESET_QUIET: assert property (disable iff (1'b0) i_rst |=> !o_irq && o_fss_n && !o_tx_dma_req)
		else $error("outputs active after reset");
	AST_RX_DMA_SYNC: assert property (o_rx_dma_req |-> $past(i_rx_fifo_service, 2))
		else $error("rx dma request without service");
endmodule
bind ssp_ctrl ssp_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .HALF_BIT(HALF_BIT))
	ssp_ctrl_asserts_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rd(i_rd),
	.i_rx_fifo_service(i_rx_fifo_service), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_rx_dma_req(o_rx_dma_req), .o_tx_dma_req(o_tx_dma_req), .o_sclk(o_sclk),
	.o_sclk_oe(o_sclk_oe), .o_mosi_oe(o_mosi_oe), .o_fss_n(o_fss_n));
`default_nettype wire

// *** ssp_ctrl_test.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_ctrl_test;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, ack = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wd = 0, q, d, rdata, seed = 47;
	logic [15:0] word;
	logic [4:0]  nbits;
	logic        irq, rxq, txq, sclk, mosi, fss_n, svc, tmo, ovr;
	logic        sclk_oe, mosi_oe;
	int          error_cnt = 0, cmp_count = 0, cyc = 0, n, w;
	initial forever #5 clk = ~clk;
	ssp_ctrl ssp_ctrl_inst (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
		.o_rx_dma_req(rxq), .o_tx_dma_req(txq), .i_rx_fifo_service(svc),
		.i_rx_timeout(tmo), .i_rx_overrun(ovr), .o_sclk(sclk),
		.o_sclk_oe(sclk_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
		.o_fss_n(fss_n));
	ssp_peer ssp_peer_inst (.i_clk(clk), .i_rst(rst), .i_sclk(sclk),
		.i_mosi(mosi), .i_fss_n(fss_n), .i_ack(ack), .o_word(word),
		.o_nbits(nbits), .o_svc(svc), .o_tmo(tmo), .o_ovr(ovr));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [31:0] msk(input int b);
		return (32'h1 << b) - 32'h1;
	endfunction
	task print_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task bw(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wd   <= v;
		wr   <= 1'b1;
		@(posedge clk);
		wr   <= 1'b0;
		@(posedge clk);
	endtask
	task br(input logic [7:0] a);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 q = rdata;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		// Whole run needs about 400 cycles
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		br(`SSP_OFF_CTRL);
		chk(q, `SSP_CTRL_RESET);
		br(`SSP_OFF_STAT);
		chk(q, 32'h6);
		br(8'hFC);
		chk(q, 32'h0);
		bw(`SSP_OFF_CTRL, 32'h10);
		br(`SSP_OFF_CTRL);
		chk(q, 32'h30);
		bw(`SSP_OFF_PUT, xs());
		br(`SSP_OFF_PUT);
		chk(q[0], 1'b0);
		bw(`SSP_OFF_MASK, 32'h0);
		bw(`SSP_OFF_DMA_SET, 32'h3);
		br(`SSP_OFF_DMA);
		chk(q, 32'h3);
		bw(`SSP_OFF_DMA_CLR, 32'h1);
		br(`SSP_OFF_DMA);
		chk(q, 32'h2);
		bw(`SSP_OFF_DMA_SET, 32'h1);
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 4 : (i == 1) ? 16 : 5 + xs() % 11;
			d = xs();
			bw(`SSP_OFF_CTRL, ((w - 1) << 4) | 1);
			bw(`SSP_OFF_DATA, d);
			br(`SSP_OFF_STAT);
			chk(q[0], 1'b1);
			chk({sclk_oe, mosi_oe}, 2'h3);
			n = 0;
			while (fss_n && n < 300) begin
				@(posedge clk);
				n++;
			end
			while (!fss_n && n < 600) begin
				@(posedge clk);
				n++;
			end
			repeat (2) @(posedge clk);
			chk(word, d & msk(w));
			chk(nbits, w);
		end
		chk(rxq, 1'b1);
		br(`SSP_OFF_RAW);
		chk(q, 32'hF);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (4) @(posedge clk);
		chk(rxq, 1'b0);
		chk(irq, 1'b0);
		br(`SSP_OFF_RAW);
		chk(q, 32'hD);
		br(`SSP_OFF_MIS);
		chk(q, 32'h0);
		bw(`SSP_OFF_MASK, 32'hC);
		chk(irq, 1'b1);
		br(`SSP_OFF_MIS);
		chk(q, 32'hC);
		bw(`SSP_OFF_ICLR, 32'h4);
		br(`SSP_OFF_RAW);
		chk(q & 32'hC, 32'h8);
		chk(irq, 1'b1);
		bw(`SSP_OFF_ICLR, 32'h8);
		chk(irq, 1'b0);
		bw(`SSP_OFF_CTRL, 32'hF1);
		n = 0;
		repeat (12) begin
			bw(`SSP_OFF_PUT, xs());
			br(`SSP_OFF_PUT);
			n += q[0];
		end
		chk(n, 9);
		chk(q[0], 1'b0);
		chk(txq, 1'b0);
		br(`SSP_OFF_STAT);
		chk(q[1], 1'b0);
		bw(`SSP_OFF_CTRL, 32'h0);
		chk(fss_n, 1'b1);
		chk(sclk_oe, 1'b0);
		chk(mosi_oe, 1'b0);
		br(`SSP_OFF_STAT);
		chk(q, 32'h6);
		print_verdict;
	end
endmodule
`default_nettype wire

// *** ssp_peer.sv ***
// Far-side serial device model with receive event lines
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
	input  wire logic  i_clk,
	input  wire logic  i_rst,
	input  wire logic  i_sclk,
	input  wire logic  i_mosi,
	input  wire logic  i_fss_n,
	input  wire logic  i_ack,
	output logic [15:0] o_word,
	output logic [4:0] o_nbits,
	output logic       o_svc,
	output logic       o_tmo,
	output logic       o_ovr
);
	logic       sclk_d;
	logic       fss_d;
	logic [5:0] age;
	always_ff @(posedge i_clk) begin
		sclk_d <= i_sclk;
		fss_d  <= i_fss_n;
		o_ovr  <= 1'b0;
		o_tmo  <= o_svc && age == 6'h1F;
		age    <= o_svc ? age + 6'h1 : 6'h0;
		if (fss_d && !i_fss_n) begin
			o_word  <= 16'h0;
			o_nbits <= 5'h0;
		end
		// Sample on rising link clock, MSB arrives first
		if (i_sclk && !sclk_d && !i_fss_n) begin
			o_word  <= {o_word[14:0], i_mosi};
			o_nbits <= o_nbits + 5'h1;
		end
		// Unread word on frame end means overrun
		if (!fss_d && i_fss_n) begin
			o_ovr <= o_svc;
			o_svc <= 1'b1;
		end
		if (i_ack || i_rst) begin
			o_svc <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** ssp_pkg.sv ***
// Types shared by the serial port control block
`default_nettype none
package ssp_pkg;
	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_SHIFT,
		SSP_LAST
	} ssp_tx_state_e;
	typedef logic [15:0] ssp_word_t;
endpackage
`default_nettype wire

// *** ssp_tx_fifo.sv ***
// Transmit FIFO holding truncated words for the shifter
`timescale 1ns/100ps
`default_nettype none
module ssp_tx_fifo
	import ssp_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic      i_sys_clk,
	input  wire logic      i_rst,
	input  wire logic      i_flush,
	input  wire logic      i_wr,
	input  wire ssp_word_t i_wr_data,
	input  wire logic      i_rd,
	output var ssp_word_t  o_rd_data,
	output logic           o_full,
	output logic           o_empty
);
	ssp_word_t      mem [DEPTH];
	logic [AW:0]    wr_ptr;
	logic [AW:0]    rd_ptr;

	assign o_empty = (wr_ptr == rd_ptr);
	assign o_full  = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign o_rd_data = mem[rd_ptr[AW-1:0]];

	// Full FIFO refuses a write silently
	always_ff @(posedge i_sys_clk) begin
		if (i_wr && !o_full)
			mem[wr_ptr[AW-1:0]] <= i_wr_data;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (i_wr && !o_full)
				wr_ptr <= wr_ptr + 1'b1;
			if (i_rd && !o_empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire
